// *** rtl/sdcp_port.sv ***
// Serial DAC command port with frame sync, serial clock, data and AHB-Lite status access.
// Overview of operation
// - Frames are 16 bits: command then data.
// - Low data positions ignored in narrow variants.
// - Input active only between sync fall and rise.
// - In chain mode, unfinished frames still execute at sync rise.
// - Reset: falling edge, chain on, zero scale.
// - Command 0000 changes nothing.
// - Command 1001 selects standalone counted mode.
// - Chain mode returns only through reset.
// - Command 1010 selects rising sample edge.
// - Commands 1011 and 1100 clear zero/midscale.
// - Command 0010 starts a readback.
// - Data accepted only while sync low.
// - Chain mode shifts on every sampling edge.
// - Chain mode overflow bits leave on data out.
// - Data out changes on non-sampling edge.
// - Chain mode executes command at sync rise.
// - Standalone sync fall clears the bit counter.
// - Standalone early sync rise aborts the write.
// - Standalone transfer at sixteenth sampling edge.
// - Standalone needs new sync fall per frame.
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
module sdcp_port
    import sdcp_pkg::*;
#(
    parameter int RES_BITS = 12
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        sync_n,
    input  wire logic        sclk,
    input  wire logic        sdin,
    output logic             serial_data_out,
    output logic      [11:0] dac_code
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] sync_meta;
    logic [1:0] sclk_meta;
    logic [1:0] din_meta;
    logic       sync_q;
    logic       sclk_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // The serial clock idles high, so its edge detector starts high.
            // A low start would show a false rising edge right after reset.
            sync_meta <= 2'h3;
            sclk_meta <= 2'h3;
            din_meta  <= 2'h0;
            sync_q    <= 1'b1;
            sclk_q    <= 1'b1;
        end else begin
            sync_meta <= {sync_meta[0], sync_n};
            sclk_meta <= {sclk_meta[0], sclk};
            din_meta  <= {din_meta[0], sdin};
            sync_q    <= sync_meta[1];
            sclk_q    <= sclk_meta[1];
        end
    end

    logic sync_s;
    logic sclk_s;
    logic din_s;
    assign sync_s = sync_meta[1];
    assign sclk_s = sclk_meta[1];
    assign din_s  = din_meta[1];

    logic sync_fall;
    logic sync_rise;
    logic sclk_rise;
    logic sclk_fall;
    assign sync_fall = sync_q && !sync_s;
    assign sync_rise = !sync_q && sync_s;
    assign sclk_rise = !sclk_q && sclk_s;
    assign sclk_fall = sclk_q && !sclk_s;

    // ------------------------------------------------------------
    // Mode state
    // ------------------------------------------------------------
    logic        chain_on;
    logic        rise_edge;
    logic        frame_open;
    logic [4:0]  bit_cnt;
    logic [15:0] shift_reg;
    logic [11:0] dac_reg;
    logic        rb_pending;
    logic [15:0] rb_word;
    logic        rb_active;

    logic sample_edge;
    logic launch_edge;
    assign sample_edge = rise_edge ? sclk_rise : sclk_fall;
    assign launch_edge = rise_edge ? sclk_fall : sclk_rise;

    // Input buffers are awake only inside a frame.
    logic in_frame;
    assign in_frame = !sync_s;

    // Standalone mode gates clocks once the counter is full.
    logic shift_ok;
    assign shift_ok = in_frame && (chain_on || (frame_open && bit_cnt < CNT_FULL));

    logic [15:0] next_shift;
    assign next_shift = {shift_reg[14:0], din_s};

    // Keeps the used data positions of the variant.
    function automatic logic [11:0] sdcp_mask(input logic [11:0] d);
        logic [11:0] m;
        m = 12'hfff << (DATA_BITS - RES_BITS);
        return d & m;
    endfunction

    // A word is executed at sync rise in chain mode or at the last bit standalone.
    // Standalone mode takes the word from the shifter input, so the sixteenth bit
    // counts even though the shift register itself has not yet taken it.
    logic        exec;
    logic [15:0] exec_word;
    assign exec = chain_on ? sync_rise :
                  (frame_open && in_frame && sample_edge && bit_cnt == CNT_FULL - 5'h01);
    assign exec_word = chain_on ? shift_reg : next_shift;

    logic [3:0] cmd;
    assign cmd = exec_word[CMD_MSB:CMD_LSB];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg <= 16'h0000;
        end else if (sample_edge && shift_ok) begin
            shift_reg <= next_shift;
        end
    end

    // The counter stops at a full frame, which in standalone mode gates further clocks off
    // until the next falling edge of frame sync.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt    <= CNT_RESET;
            frame_open <= 1'b0;
        end else if (sync_fall) begin
            bit_cnt    <= CNT_RESET;
            frame_open <= 1'b1;
        end else if (sync_rise) begin
            frame_open <= 1'b0;
        end else if (sample_edge && shift_ok && bit_cnt < CNT_FULL) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chain_on <= 1'b1;
        end else if (exec && cmd == CMD_CHAINOFF) begin
            chain_on <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rise_edge <= 1'b0;
        end else if (exec && cmd == CMD_RISEEDGE) begin
            rise_edge <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_reg <= DAC_RESET;
        end else if (exec) begin
            case (cmd)
                CMD_LOAD: begin
                    dac_reg <= sdcp_mask(exec_word[11:0]);
                end
                CMD_ZERO: begin
                    dac_reg <= DAC_RESET;
                end
                CMD_MID: begin
                    dac_reg <= DAC_MIDSCALE;
                end
                default: begin
                    dac_reg <= dac_reg;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rb_pending <= 1'b0;
        end else if (exec && cmd == CMD_READBACK) begin
            rb_pending <= 1'b1;
        end else if (sync_fall) begin
            rb_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Serial data out
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rb_active <= 1'b0;
            rb_word   <= 16'h0000;
        end else if (sync_fall) begin
            rb_active <= rb_pending;
            rb_word   <= {CMD_NOP, dac_reg};
        end else if (rb_active && launch_edge && in_frame) begin
            rb_word <= {rb_word[14:0], 1'b0};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_data_out <= 1'b0;
        end else if (sync_fall && rb_pending) begin
            // The readback word leads with its all-zero command field.
            serial_data_out <= CMD_NOP[3];
        end else if (launch_edge && in_frame) begin
            if (rb_active) begin
                serial_data_out <= rb_word[14];
            end else begin
                serial_data_out <= shift_reg[15];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_code <= DAC_RESET;
        end else begin
            dac_code <= dac_reg;
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite status slave
    // ------------------------------------------------------------
    // Read data are registered in the address phase, so they stand in the
    // data phase and the slave never needs a wait state.
    logic       rd_pend;
    logic [7:0] rd_addr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend <= 1'b0;
            rd_addr <= 8'h00;
        end else if (hready) begin
            rd_pend <= hsel && htrans[1] && !hwrite;
            rd_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                REG_DAC_VALUE: hrdata <= {20'h00000, dac_reg};
                REG_STATUS:    hrdata <= {26'h0000000, bit_cnt, chain_on} |
                                         {24'h000000, rise_edge, 7'h00};
                REG_VARIANT:   hrdata <= 32'(RES_BITS);
                default:       hrdata <= 32'h00000000;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_load_exec;
        exec && cmd == CMD_LOAD;
    endsequence

    a_reset_default: assert property (@(posedge hclk)
        $rose(hresetn) |-> chain_on && !rise_edge && dac_reg == DAC_RESET)
        else $error("defaults not set after reset");
    a_chain_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        !chain_on |=> !chain_on)
        else $error("chain mode came back");
    a_chain_off_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd == CMD_CHAINOFF |=> !chain_on)
        else $error("chain disable ignored");
    a_edge_select: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd == CMD_RISEEDGE |=> rise_edge)
        else $error("edge select ignored");
    a_load_update: assert property (@(posedge hclk) disable iff (!hresetn)
        s_load_exec |=> dac_reg == sdcp_mask($past(exec_word[11:0])))
        else $error("load did not update");
    a_mid_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd == CMD_MID |=> dac_reg == DAC_MIDSCALE ##1 dac_code == DAC_MIDSCALE)
        else $error("midscale clear failed");
    a_nop_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && (cmd == CMD_NOP || cmd == 4'h3) |=> $stable(dac_reg))
        else $error("nop changed dac");
    a_idle_no_shift: assert property (@(posedge hclk) disable iff (!hresetn)
        sync_s && $past(sync_s) |=> $stable(shift_reg))
        else $error("shift outside frame");
    a_count_limit: assert property (@(posedge hclk) disable iff (!hresetn)
        bit_cnt <= CNT_FULL)
        else $error("counter overran");

    // ------------------------------------------------------------
    // Frame control, clear, mask and bus read checks
    // ------------------------------------------------------------
    sequence s_readback_exec;
        exec && cmd == CMD_READBACK;
    endsequence

    sequence s_counter_full;
        !chain_on && bit_cnt == CNT_FULL;
    endsequence

    a_count_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        sync_fall |=> bit_cnt == CNT_RESET && frame_open)
        else $error("counter not cleared at frame start");

    a_zero_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        exec && cmd == CMD_ZERO |=> dac_reg == DAC_RESET)
        else $error("zero scale clear failed");

    a_readback_arm: assert property (@(posedge hclk) disable iff (!hresetn)
        s_readback_exec |=> rb_pending)
        else $error("readback not armed");

    a_readback_lead: assert property (@(posedge hclk) disable iff (!hresetn)
        sync_fall && rb_pending |=> serial_data_out == CMD_NOP[3])
        else $error("readback word does not lead with its command field");

    a_abort_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !chain_on && sync_rise |=> $stable(dac_reg))
        else $error("aborted frame changed the dac");

    a_gate_full: assert property (@(posedge hclk) disable iff (!hresetn)
        s_counter_full |=> $stable(shift_reg))
        else $error("shift after a full standalone frame");

    a_chain_shift: assert property (@(posedge hclk) disable iff (!hresetn)
        chain_on && in_frame && sample_edge |=> shift_reg == $past(next_shift))
        else $error("chain mode clock edge lost");

    a_last_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        !chain_on && frame_open && in_frame && sample_edge && !sync_fall &&
        bit_cnt == CNT_FULL - 5'h01 |=> bit_cnt == CNT_FULL)
        else $error("sixteenth bit not counted");

    a_idle_out_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        sync_s |=> $stable(serial_data_out))
        else $error("data out moved outside a frame");

    a_low_bits: assert property (@(posedge hclk) disable iff (!hresetn)
        (dac_reg & ~sdcp_mask(12'hfff)) == 12'h000)
        else $error("ignored data positions reached the dac");

    a_read_variant: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_pend && rd_addr == REG_VARIANT |-> hrdata == 32'(RES_BITS))
        else $error("variant read wrong");

endmodule

// *** rtl/sdcp_pkg.sv ***
// Shared constants and types of the serial DAC command port.
package sdcp_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CMD_BITS   = 4;
    localparam int DATA_BITS  = 12;
    localparam int CMD_MSB    = 15;
    localparam int CMD_LSB    = 12;

    // ------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_NOP      = 4'h0;
    localparam logic [3:0] CMD_LOAD     = 4'h1;
    localparam logic [3:0] CMD_READBACK = 4'h2;
    localparam logic [3:0] CMD_CHAINOFF = 4'h9;
    localparam logic [3:0] CMD_RISEEDGE = 4'ha;
    localparam logic [3:0] CMD_ZERO     = 4'hb;
    localparam logic [3:0] CMD_MID      = 4'hc;

    // ------------------------------------------------------------
    // Reset, midscale and counter-full values
    // ------------------------------------------------------------
    localparam logic [11:0] DAC_RESET    = 12'h000;
    localparam logic [11:0] DAC_MIDSCALE = 12'h800;
    localparam logic [4:0]  CNT_RESET    = 5'h00;
    localparam logic [4:0]  CNT_FULL     = 5'h10;

    // ------------------------------------------------------------
    // Bus register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_DAC_VALUE = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_VARIANT   = 8'h08;

    // Bus-side write channel states.
    typedef enum logic [1:0] {
        SDCP_IDLE = 2'b00,
        SDCP_ADDR = 2'b01
    } sdcp_bus_t;

endpackage

// *** tb/sdcp_host.sv ***
// Host serial master model that drives frame sync, serial clock and data.
module sdcp_host (
    output logic      sync_n,
    output logic      sclk,
    output logic      sdin,
    input  wire logic din_back,
    input  wire logic rise
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] cap;
    initial begin
        sync_n = 1'b1;
        sclk   = 1'b1;
        sdin   = 1'b0;
        cap    = '0;
    end
    // Sends the low n bits of w, MSB first; lowers sync_n first only if gate is set and never raises it.
    task automatic send(input logic [31:0] w, input int n, input logic gate);
        if (gate && sync_n) begin
            sync_n = 1'b0;
            #32;
        end
        for (int i = n - 1; i >= 0; i--) begin
            sdin = w[i];
            #16;
            if (!rise) cap = {cap[30:0], din_back};
            sclk = 1'b0;
            #32;
            if (rise) cap = {cap[30:0], din_back};
            sclk = 1'b1;
            #16;
        end
    endtask
    // The clock stands still and the released data line flips.
    task automatic close();
        #32;
        sync_n = 1'b1;
        sdin   = ~sdin;
    endtask
endmodule

// *** tb/tb_serial_dac_command_port.sv ***
// Self-checking bench of the serial DAC command port.
module tb_serial_dac_command_port
    import sdcp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        sync_n, sclk, sdin, ser_out, rise, m_chain, m_rise;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd, rd_q;
    logic [11:0] dac_code, m_dac;
    logic [15:0] m_sr, w, a;
    logic [3:0]  cmds [$] = '{4'h1, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                              4'hd, 4'he, 4'hf, 4'hb, 4'h1, 4'hc};
    int          fail_count, num_checks, rnd;

    sdcp_port #(.RES_BITS(10)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sync_n(sync_n),
        .sclk(sclk), .sdin(sdin), .serial_data_out(ser_out), .dac_code(dac_code));
    sdcp_host host_u (
        .sync_n(sync_n), .sclk(sclk), .sdin(sdin), .din_back(ser_out), .rise(rise));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) rd_q <= hrdata;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ahb(input logic [31:0] ad, input logic wr, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= ad;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
        htrans <= 2'b00;
        hwdata <= 32'h0000ffff;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
        #1 d = rd_q;
        check("hresp", {31'h0, hresp}, 32'h0);
        if (n >= 99) fail_count++;
    endtask
    function automatic void apply(input logic [15:0] f);
        case (f[15:12])
            CMD_LOAD:     m_dac = f[11:0] & 12'hffc;
            CMD_CHAINOFF: m_chain = 1'b0;
            CMD_RISEEDGE: m_rise = 1'b1;
            CMD_ZERO:     m_dac = 12'h000;
            CMD_MID:      m_dac = 12'h800;
            default:      ;
        endcase
    endfunction
    task automatic chk_dac();
        repeat (12) @(posedge hclk);
        check("dac_code", {20'h0, dac_code}, {20'h0, m_dac});
        ahb(REG_DAC_VALUE, 1'b0, rd);
        check("dac_reg", rd, {20'h0, m_dac});
    endtask
    task automatic frame(input logic [15:0] f, input int n);
        host_u.send({16'h0, f}, n, 1'b1);
        m_sr = 16'((m_sr << n) | (f & ((1 << n) - 1)));
        host_u.close();
        if (m_chain || n == 16) apply(m_sr);
        chk_dac();
    endtask
    task automatic status(input logic [31:0] exp);
        ahb(REG_STATUS, 1'b0, rd);
        check("status", rd & 32'h81, exp);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #400us;
        fail_count++;
        print_verdict();
    end

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, rise} = '0;
        {m_dac, m_sr, m_rise, fail_count, num_checks} = '0;
        m_chain = 1'b1;
        rnd = $urandom(74401);
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        status(32'h1);
        ahb(REG_VARIANT, 1'b0, rd);
        check("variant", rd, 32'd10);
        ahb(32'h0c, 1'b0, rd);
        check("unmapped", rd, 32'h0);
        ahb(REG_DAC_VALUE, 1'b1, rd);
        chk_dac();
        host_u.send(32'h1fff, 16, 1'b0);
        chk_dac();
        foreach (cmds[i]) frame({cmds[i], 12'($urandom)}, 16);
        status(32'h1);
        a = {4'h0, 12'($urandom)};
        w = {4'h1, 4'($urandom), 4'h1, 4'($urandom)};
        host_u.send({a, w}, 32, 1'b1);
        host_u.close();
        m_sr = w;
        apply(w);
        check("chain_out", host_u.cap[15:0], a);
        chk_dac();
        frame(16'($urandom), 8);
        frame({CMD_READBACK, 12'h0}, 16);
        frame(16'h0, 16);
        check("readback", host_u.cap[15:0], {4'h0, m_dac});
        frame({CMD_RISEEDGE, 12'h0}, 16);
        rise = m_rise;
        status(32'h81);
        frame({CMD_LOAD, 12'($urandom)}, 16);
        frame({CMD_CHAINOFF, 12'h0}, 16);
        status(32'h80);
        w = {CMD_LOAD, 12'($urandom)};
        host_u.send({16'h0, w}, 16, 1'b1);
        apply(w);
        repeat (12) @(posedge hclk);
        check("early", {20'h0, dac_code}, {20'h0, m_dac});
        host_u.send(32'h1fff, 16, 1'b1);
        host_u.close();
        chk_dac();
        frame({CMD_LOAD, 12'hfff}, 8);
        for (int c = 0; c < 16; c++) frame({4'(c), 12'h555}, 16);
        status(32'h80);
        print_verdict();
    end
endmodule
